// file: src/msrp_top.sv
// receive pin logic of one MII or four-lane serial port, with core-side hand-over
// Operation
// - mii nibble sampled on phy receive clock
// - each pin line is one lane of the serial port
// - serial data taken on rising link clock edge
// - nibbles accepted only while data valid high
// - source-sync pulse starts next 10-bit segment
// - collision used in mii, ignored in serial
// - carrier sense synchronised before use
// - serial mode drives sync every 10 clocks
// - source-sync transmit sync every 10 clocks
// - carrier/sync pin direction follows mode
`timescale 1ns/1ps
`include "msrp_cfg.svh"
module msrp_top #(
    parameter int LANES = `MSRP_LANES,
    parameter int SEG_BITS = `MSRP_SEG_BITS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire msrp_pkg::msrp_mode_e mode_select,
    input wire logic phy_receive_clock,
    input wire logic source_sync_transmit_clock,
    input wire logic [LANES-1:0] mii_receive_nibble,
    input wire logic receive_data_valid,
    input wire logic collision_input,
    input wire logic carrier_sense_input,
    output logic segment_sync_out,
    output logic segment_sync_oe,
    output logic transmit_segment_sync,
    output logic transmit_segment_sync_oe,
    output logic [LANES-1:0] rx_nibble,
    output logic rx_nibble_valid,
    output logic [LANES*SEG_BITS-1:0] rx_segment,
    output logic rx_segment_valid,
    output logic collision,
    output logic carrier_sense
);
    import msrp_pkg::*;

    // ---------------- core domain ----------------
    msrp_mode_e mode_q; // registered mode, source of all crossings
    logic [3:0] sy1; // first synchroniser stage
    logic [3:0] sy2; // second stage
    logic [1:0] sy3; // edge detect stage for the two toggles
    logic nib_edge; // new nibble from the link side
    logic seg_edge; // new segment from the link side

    // ---------------- link domain ----------------
    logic [1:0] lrst; // reset synchroniser, link side
    logic lrst_n;
    msrp_mode_e mode_l1; // mode synchroniser
    msrp_mode_e mode_l;
    logic [LANES-1:0] in_lines; // sampled nibble / serial lines
    logic in_dv; // sampled data valid / receive sync
    logic in_col; // sampled collision
    msrp_cnt_t gen_cnt; // sync generator position
    msrp_cnt_t bit_cnt; // receive bit position
    msrp_cnt_t idx; // index of the bit in in_lines
    logic sync_d; // sync pulse aligned with its first data bit
    logic start; // in_lines holds bit 0 of a segment
    logic [LANES-1:0] hold_nib; // captured nibble, stable for the core
    logic nib_tog; // flips per captured nibble
    logic [LANES*SEG_BITS-1:0] hold_seg; // captured segments
    logic seg_tog; // flips per captured segment set
    logic col_l; // collision, forced low outside mii
    logic [SEG_BITS-2:0] shreg [LANES]; // per-lane shift registers

    // ---------------- transmit sync domain ----------------
    logic [1:0] trst;
    logic trst_n;
    msrp_mode_e mode_t1;
    msrp_mode_e mode_t;
    msrp_cnt_t tx_cnt;

    // next position inside a segment, wraps after the last bit
    function automatic msrp_cnt_t seg_next(input msrp_cnt_t c);
        seg_next = (c == `MSRP_SEG_LAST) ? `MSRP_SEG_FIRST : msrp_cnt_t'(c + 4'h1);
    endfunction

    // mode register, frozen by the clock enable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= MSRP_MODE_MII;
        end else if (clock_enable) begin
            mode_q <= mode_select;
        end
    end

    // link side reset release
    always_ff @(posedge phy_receive_clock) begin
        lrst <= {lrst[0], rst_n};
    end
    assign lrst_n = lrst[1];

    // mode into the link domain; mode is static while the link runs
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            mode_l1 <= MSRP_MODE_MII;
            mode_l <= MSRP_MODE_MII;
        end else begin
            mode_l1 <= mode_q;
            mode_l <= mode_l1;
        end
    end

    // pins are synchronous to this clock: one sampling stage
    always_ff @(posedge phy_receive_clock) begin
        in_lines <= mii_receive_nibble;
        in_dv <= receive_data_valid;
        in_col <= collision_input;
    end

    // free-running segment sync generator, pin driven only in serial mode
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            gen_cnt <= `MSRP_SEG_FIRST;
            segment_sync_out <= 1'b0;
            segment_sync_oe <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            gen_cnt <= seg_next(gen_cnt);
            segment_sync_out <= (mode_l == MSRP_MODE_SMII) && (gen_cnt == `MSRP_SEG_LAST);
            segment_sync_oe <= (mode_l == MSRP_MODE_SMII);
            sync_d <= segment_sync_out; // phy answers with bit 0 in the pulse cycle
        end
    end

    // segment start: own pulse in serial mode, phy pulse in source-sync
    assign start = (mode_l == MSRP_MODE_SSMII) ? in_dv : (mode_l == MSRP_MODE_SMII) && sync_d;
    assign idx = start ? `MSRP_SEG_FIRST : bit_cnt;

    // receive bit position
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            bit_cnt <= `MSRP_SEG_FIRST;
        end else begin
            bit_cnt <= seg_next(idx);
        end
    end

    // one shift register per lane, first bit ends in the msb
    for (genvar n = 0; n < LANES; n++) begin : g_lane
        always_ff @(posedge phy_receive_clock) begin
            if (!lrst_n) begin
                shreg[n] <= '0;
                hold_seg[n*SEG_BITS +: SEG_BITS] <= '0;
            end else begin
                shreg[n] <= {shreg[n][SEG_BITS-3:0], in_lines[n]};
                if (idx == `MSRP_SEG_LAST && mode_l != MSRP_MODE_MII) begin
                    hold_seg[n*SEG_BITS +: SEG_BITS] <= {shreg[n], in_lines[n]};
                end
            end
        end
    end

    // segment completion event for the core
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            seg_tog <= 1'b0;
        end else if (idx == `MSRP_SEG_LAST && mode_l != MSRP_MODE_MII) begin
            seg_tog <= ~seg_tog;
        end
    end

    // mii nibble capture, gated by data valid
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            hold_nib <= `MSRP_NIB_RST;
            nib_tog <= 1'b0;
        end else if (mode_l == MSRP_MODE_MII && in_dv) begin
            hold_nib <= in_lines;
            nib_tog <= ~nib_tog;
        end
    end

    // collision only has meaning in mii mode
    always_ff @(posedge phy_receive_clock) begin
        if (!lrst_n) begin
            col_l <= 1'b0;
        end else begin
            col_l <= (mode_l == MSRP_MODE_MII) && in_col;
        end
    end

    // transmit sync domain reset and mode
    always_ff @(posedge source_sync_transmit_clock) begin
        trst <= {trst[0], rst_n};
    end
    assign trst_n = trst[1];

    // transmit segment sync every 10 transmit clocks in source-sync mode
    always_ff @(posedge source_sync_transmit_clock) begin
        if (!trst_n) begin
            mode_t1 <= MSRP_MODE_MII;
            mode_t <= MSRP_MODE_MII;
            tx_cnt <= `MSRP_SEG_FIRST;
            transmit_segment_sync <= 1'b0;
            transmit_segment_sync_oe <= 1'b0;
        end else begin
            mode_t1 <= mode_q;
            mode_t <= mode_t1;
            tx_cnt <= seg_next(tx_cnt);
            transmit_segment_sync <= (mode_t == MSRP_MODE_SSMII) && (tx_cnt == `MSRP_SEG_LAST);
            transmit_segment_sync_oe <= (mode_t == MSRP_MODE_SSMII);
        end
    end

    // core synchronisers: nibble toggle, segment toggle, collision, carrier
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sy1 <= 4'h0;
            sy2 <= 4'h0;
            sy3 <= 2'h0;
        end else if (clock_enable) begin
            sy1 <= {carrier_sense_input, col_l, seg_tog, nib_tog};
            sy2 <= sy1;
            sy3 <= sy2[1:0];
        end
    end
    assign nib_edge = sy2[0] ^ sy3[0];
    assign seg_edge = sy2[1] ^ sy3[1];

    // hand-over: hold registers are stable long before the toggle arrives
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_nibble <= `MSRP_NIB_RST;
            rx_nibble_valid <= 1'b0;
            rx_segment <= '0;
            rx_segment_valid <= 1'b0;
        end else if (clock_enable) begin
            rx_nibble_valid <= nib_edge;
            rx_segment_valid <= seg_edge;
            if (nib_edge) begin
                rx_nibble <= hold_nib;
            end
            if (seg_edge) begin
                rx_segment <= hold_seg;
            end
        end
    end

    // collision and carrier levels, carrier only in mii mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            collision <= 1'b0;
            carrier_sense <= 1'b0;
        end else if (clock_enable) begin
            collision <= sy2[2] && (mode_q == MSRP_MODE_MII);
            carrier_sense <= sy2[3] && (mode_q == MSRP_MODE_MII);
        end
    end

    // sync pulse followed by nine quiet clocks then the next pulse
    sequence s_quiet_gap;
        !segment_sync_out [*8] ##1 !segment_sync_out;
    endsequence
    chk_sync_period: assert property (@(posedge phy_receive_clock) disable iff (!lrst_n)
        (segment_sync_out && mode_l == MSRP_MODE_SMII) |=>
        s_quiet_gap ##1 (segment_sync_out || mode_l != MSRP_MODE_SMII))
        else $error("segment sync not every 10 clocks");
    // transmit sync pulse followed by nine quiet transmit clocks
    sequence s_tx_quiet_gap;
        !transmit_segment_sync [*8] ##1 !transmit_segment_sync;
    endsequence
    chk_tx_sync_period: assert property (@(posedge source_sync_transmit_clock) disable iff (!trst_n)
        transmit_segment_sync |=>
        s_tx_quiet_gap ##1 (transmit_segment_sync || mode_t != MSRP_MODE_SSMII))
        else $error("transmit sync not every 10 clocks");
    chk_mii_capture: assert property (@(posedge phy_receive_clock) disable iff (!lrst_n)
        (mode_l == MSRP_MODE_MII && in_dv) |=> (hold_nib == $past(in_lines) && nib_tog != $past(nib_tog)))
        else $error("valid nibble not captured");
    chk_mii_gate: assert property (@(posedge phy_receive_clock) disable iff (!lrst_n)
        !in_dv |=> $stable(nib_tog))
        else $error("nibble taken without data valid");
    chk_rxsync_align: assert property (@(posedge phy_receive_clock) disable iff (!lrst_n)
        (mode_l == MSRP_MODE_SSMII && in_dv) |=> ##9 (seg_tog != $past(seg_tog)))
        else $error("segment not closed 10 bits after sync");
    chk_col_ignore: assert property (@(posedge clock) disable iff (!rst_n)
        (clock_enable && mode_q != MSRP_MODE_MII) |=> !collision)
        else $error("collision reported outside mii");
    chk_pin_dir: assert property (@(posedge phy_receive_clock) disable iff (!lrst_n)
        (mode_l == MSRP_MODE_SMII) [*2] |-> segment_sync_oe)
        else $error("sync pin not driven in serial mode");
    chk_crs_sync: assert property (@(posedge clock) disable iff (!rst_n)
        (clock_enable && mode_q == MSRP_MODE_MII && carrier_sense_input) [*4] |-> carrier_sense)
        else $error("carrier not reported after synchroniser");
    chk_nib_handoff: assert property (@(posedge clock) disable iff (!rst_n)
        (clock_enable && nib_edge) |=> (rx_nibble_valid && rx_nibble == $past(hold_nib)))
        else $error("nibble hand-over wrong");
    chk_seg_handoff: assert property (@(posedge clock) disable iff (!rst_n)
        (clock_enable && seg_edge) |=> (rx_segment_valid && rx_segment == $past(hold_seg)))
        else $error("segment hand-over wrong");
endmodule

// file: src/msrp_cfg.svh
// timing counts, lane counts and reset values of the receive port
`ifndef MSRP_CFG_SVH
`define MSRP_CFG_SVH
// bits in one serial segment, every 10 link clocks
`define MSRP_SEG_BITS 10
// last bit index inside a segment
`define MSRP_SEG_LAST 4'h9
// first bit index inside a segment
`define MSRP_SEG_FIRST 4'h0
// serial lanes sharing the nibble pins
`define MSRP_LANES 4
// serial reference and source-synchronous clock rate in MHz
`define MSRP_REF_MHZ 125
// nibble value held after reset
`define MSRP_NIB_RST 4'h0
`endif

// file: src/msrp_pkg.sv
// types of the receive port: interface mode selection
package msrp_pkg;
    // pin interface mode, one-hot
    typedef enum logic [2:0] {
        MSRP_MODE_MII   = 3'b001,
        MSRP_MODE_SMII  = 3'b010,
        MSRP_MODE_SSMII = 3'b100
    } msrp_mode_e;
    // bit counter inside a serial segment
    typedef logic [3:0] msrp_cnt_t;
endpackage

// file: tb/msrp_phy_model.sv
// phy model: mii nibbles, serial lanes, carrier and collision
`timescale 1ns/1ps
module msrp_phy_model (
    input wire logic lclk,
    input wire msrp_pkg::msrp_mode_e mode,
    input wire logic sync_in,
    output logic [3:0] nib,
    output logic dv,
    output logic col,
    output logic crs
);
    import msrp_pkg::*;
    logic [39:0] src_q[$]; // words waiting to be sent
    logic [39:0] exp_q[$]; // results the port must deliver
    logic [39:0] w = 40'h0; // word in flight
    logic arm = 1'b0; // a real word is on the lanes
    int idx = 0; // bit index inside a segment
    // idle lines at time zero
    initial begin
        {nib, dv, col, crs} = 7'h78;
    end
    // drive just after each link edge
    always @(posedge lclk) begin
        #1;
        if (mode == MSRP_MODE_MII) begin
            if (src_q.size() > 0) begin
                w = src_q.pop_front();
                {dv, nib} = w[4:0];
                if (w[4]) exp_q.push_back(w);
            end else begin
                {dv, nib} = {1'b0, ~nib}; // idle lines toggle
            end
        end else begin
            idx = (mode == MSRP_MODE_SMII && sync_in) ? 0 : (idx + 1) % 10;
            if (idx == 0) begin
                arm = src_q.size() > 0;
                if (arm) w = src_q.pop_front();
            end
            dv = (mode == MSRP_MODE_SSMII) && idx == 0;
            // pulled-up lines sit high between words
            for (int n = 0; n < 4; n++) nib[n] = arm ? w[n*10+9-idx] : 1'b1;
            if (arm && idx == 9) exp_q.push_back(w);
        end
    end
    // carrier rises off-edge, collision and release on edges
    task automatic collide(input int n);
        #37 crs = 1'b1;
        @(posedge lclk) #1 col = 1'b1;
        repeat (n) @(posedge lclk);
        #1 {col, crs} = 2'b00;
    endtask
endmodule

// file: tb/msrp_top_tb.sv
// self-checking bench of the receive port against a phy model
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module msrp_top_tb;
    import msrp_pkg::*;
    logic clock = 1'b0; // core clock
    logic lclk = 1'b0; // link receive clock
    logic txclk = 1'b0; // transmit clock
    logic rst_n = 1'b0; // sync reset
    logic clock_enable = 1'b1; // core always runs
    msrp_mode_e mode = MSRP_MODE_MII; // interface mode
    logic [3:0] nib; // lanes from phy
    logic dv, col, crs; // phy status lines
    logic sso, ssoe, tss, tssoe, rxnv, rxsv, coll, crso; // port outputs
    logic [3:0] rxn; // captured nibble
    logic [39:0] rxs, e; // captured segments, expected
    logic [63:0] seed = 64'h46; // xorshift state
    int err_count = 0; // mismatches
    int total_checks = 0; // comparisons
    int sgap = 0; // link clocks since segment sync
    int tgap = 0; // tx clocks since transmit sync
    int pend; // words still in flight
    initial forever #5 clock = ~clock;
    // link clock from the phy side, 16 times slower than the core clock so every toggle reaches the core
    initial begin
        #3;
        forever #80 lclk = ~lclk;
    end
    initial begin
        #41;
        forever #80 txclk = ~txclk;
    end
    msrp_top DUT (.clock(clock), .rst_n(rst_n), .clock_enable(clock_enable), .mode_select(mode),
        .phy_receive_clock(lclk), .source_sync_transmit_clock(txclk), .mii_receive_nibble(nib),
        .receive_data_valid(dv), .collision_input(col), .carrier_sense_input(crs),
        .segment_sync_out(sso), .segment_sync_oe(ssoe), .transmit_segment_sync(tss),
        .transmit_segment_sync_oe(tssoe), .rx_nibble(rxn), .rx_nibble_valid(rxnv),
        .rx_segment(rxs), .rx_segment_valid(rxsv), .collision(coll), .carrier_sense(crso));
    msrp_phy_model phy (.lclk(lclk), .mode(mode), .sync_in(sso), .nib(nib), .dv(dv), .col(col), .crs(crs));
    // xorshift source of words
    function automatic logic [39:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed[39:0];
    endfunction
    // oldest note against each delivered result
    always @(posedge clock) begin
        if (rxnv === 1'b1 || rxsv === 1'b1) begin
            if (phy.exp_q.size() == 0) begin
                if (mode == MSRP_MODE_MII) `CHK(1'b1, 1'b0)
            end else begin
                e = phy.exp_q.pop_front();
                if (mode == MSRP_MODE_MII) `CHK(rxn, e[3:0])
                else `CHK(rxs, e)
            end
        end
    end
    // spacing of serial sync pulses
    always @(posedge lclk) begin
        sgap <= !rst_n ? 0 : sso === 1'b1 ? 1 : sgap == 0 ? 0 : sgap + 1;
        if (sso === 1'b1 && sgap > 0 && mode == MSRP_MODE_SMII) `CHK(sgap, 10)
    end
    always @(posedge txclk) begin
        tgap <= !rst_n ? 0 : tss === 1'b1 ? 1 : tgap == 0 ? 0 : tgap + 1;
        if (tss === 1'b1 && tgap > 0 && mode == MSRP_MODE_SSMII) `CHK(tgap, 10)
    end
    // verdict and end of run
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one mode: reset, traffic, drain, collision
    task automatic run_mode(input msrp_mode_e m);
        logic [39:0] w;
        @(posedge clock);
        mode <= m;
        rst_n <= 1'b0;
        repeat (4) @(posedge lclk);
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (24) @(posedge lclk);
        `CHK(ssoe, logic'(m == MSRP_MODE_SMII))
        `CHK(tssoe, logic'(m == MSRP_MODE_SSMII))
        for (int i = 0; i < 24; i++) begin
            w = rnd();
            if (m == MSRP_MODE_MII) w = {35'h0, w[4:0]};
            phy.src_q.push_back(w);
        end
        pend = 1;
        for (int t = 0; t < 6000 && pend != 0; t++) begin
            @(posedge clock);
            pend = phy.src_q.size() + phy.exp_q.size();
        end
        // sync pulses appear only in their own serial mode
        `CHK(sgap inside {[1:10]}, m == MSRP_MODE_SMII)
        `CHK(tgap inside {[1:10]}, m == MSRP_MODE_SSMII)
        `CHK(pend, 0)
        if (pend != 0) close_out();
        fork
            phy.collide(8);
            begin
                // collision reaches the pins up to two link clocks late, then two more to the core
                repeat (6) @(posedge lclk);
                `CHK(coll, logic'(m == MSRP_MODE_MII))
                `CHK(crso, logic'(m == MSRP_MODE_MII))
            end
        join
        repeat (3) @(posedge lclk);
        `CHK(coll, 1'b0)
        `CHK(crso, 1'b0)
    endtask
    // main sequence over every mode
    initial begin
        run_mode(MSRP_MODE_MII);
        run_mode(MSRP_MODE_SMII);
        run_mode(MSRP_MODE_SSMII);
        close_out();
    end
endmodule
